// ### src/srxeu_defines.vh
// Constants for the subtract / rotate / xor execution unit.
// Assumes inclusion by bare name from the unit's design files.
`ifndef SRXEU_DEFINES_VH
`define SRXEU_DEFINES_VH
// ==========================================================
// Operation codes (binary command select)
`define SRXEU_OP_W           4
`define SRXEU_OP_NOP         4'h0
`define SRXEU_OP_ROT_RC      4'h1
`define SRXEU_OP_LIT_SUB     4'h2
`define SRXEU_OP_REG_SUB     4'h3
`define SRXEU_OP_REG_SUBB    4'h4
`define SRXEU_OP_SLEEP       4'h5
`define SRXEU_OP_NIB_X       4'h6
`define SRXEU_OP_DIR_LOAD    4'h7
`define SRXEU_OP_XOR_LIT     4'h8
`define SRXEU_OP_XOR_REG     4'h9
// ==========================================================
// Direction-load operand codes
`define SRXEU_DIR_PORT_A     7'h05
`define SRXEU_DIR_PORT_B     7'h06
`define SRXEU_DIR_PORT_C     7'h07
// ==========================================================
// APB register byte offsets
`define SRXEU_REG_CTRL       12'h000
`define SRXEU_REG_OPND       12'h004
`define SRXEU_REG_ACC        12'h008
`define SRXEU_REG_STATUS     12'h00c
`define SRXEU_REG_RESULT     12'h010
`define SRXEU_REG_FILE       12'h014
`define SRXEU_REG_DIR        12'h018
`define SRXEU_REG_WDOG       12'h01c
// ==========================================================
// Control register fields
`define SRXEU_CTRL_GO        4
`define SRXEU_CTRL_DEST      5
`define SRXEU_CTRL_WAKE      6
// Status register fields
`define SRXEU_ST_C           0
`define SRXEU_ST_DC          1
`define SRXEU_ST_Z           2
`define SRXEU_ST_PWRDN       3
`define SRXEU_ST_TMOUT       4
`define SRXEU_ST_SLEEP       5
// ==========================================================
// Reset values
`define SRXEU_RST_STATUS     5'h18
`define SRXEU_RST_BYTE       8'h00
`define SRXEU_RST_DIR        8'hff
`define SRXEU_WDOG_CLEAR     8'h00
`endif

// ### src/srxeu_alu.v
// Combinational arithmetic core of the execution unit.
// Assumes operands are stable register outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "srxeu_defines.vh"
module srxeu_alu (
  input  wire [3:0] op_i,
  input  wire [7:0] acc_i,
  input  wire [7:0] file_i,
  input  wire [7:0] lit_i,
  input  wire       carry_i,
  output reg  [7:0] res_o,
  output reg        carry_o,
  output reg        dc_o,
  output wire       zero_o
);
  // ==========================================================
  // Subtraction as minuend + ~subtrahend + carry-in
  reg  [7:0] minuend;
  reg        cin;
  wire [8:0] full_sum;
  wire [4:0] low_sum;

  always @* begin
    minuend = (op_i == `SRXEU_OP_LIT_SUB) ? lit_i : file_i;
    // Borrow chain uses the inverted carry as borrow
    cin     = (op_i == `SRXEU_OP_REG_SUBB) ? carry_i : 1'b1;
  end

  assign full_sum = {1'b0, minuend} + {1'b0, ~acc_i} + {8'h00, cin};
  assign low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~acc_i[3:0]} + {4'h0, cin};

  // ==========================================================
  // Result and flag selection
  always @* begin
    res_o   = acc_i;
    carry_o = carry_i;
    dc_o    = 1'b0;
    case (op_i)
      `SRXEU_OP_ROT_RC: begin
        res_o   = {carry_i, file_i[7:1]};
        carry_o = file_i[0];
      end
      `SRXEU_OP_LIT_SUB, `SRXEU_OP_REG_SUB, `SRXEU_OP_REG_SUBB: begin
        res_o   = full_sum[7:0];
        carry_o = full_sum[8];
        dc_o    = low_sum[4];
      end
      `SRXEU_OP_NIB_X:   res_o = {file_i[3:0], file_i[7:4]};
      `SRXEU_OP_XOR_LIT: res_o = acc_i ^ lit_i;
      `SRXEU_OP_XOR_REG: res_o = acc_i ^ file_i;
      default: res_o = acc_i;
    endcase
  end

  assign zero_o = (res_o == 8'h00);
endmodule // srxeu_alu
`default_nettype wire

// ### src/srxeu_top.v
// APB-reachable execution unit for subtract, rotate, swap, xor,
// direction load and sleep entry on an 8-bit accumulator machine.
// Assumes a single 20 MHz clock and an APB master on that clock.
`timescale 1ns/1ps
`default_nettype none
`include "srxeu_defines.vh"
module srxeu_top #(
  parameter WDOG_PRESC_W = 8
) (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        clk_en_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg  [7:0]  port_a_direction_o,
  output reg  [7:0]  port_b_direction_o,
  output reg  [7:0]  port_c_direction_o,
  output reg         osc_halt_o,
  output reg         busy_o
);
  // ==========================================================
  // State of the unit
  reg [7:0]  acc_ff;
  reg [7:0]  file_ff;
  reg [7:0]  lit_ff;
  reg [6:0]  faddr_ff;
  reg [3:0]  op_ff;
  reg        dest_ff;
  reg        carry_ff;
  reg        digit_carry_flag_ff;
  reg        zero_ff;
  reg        timeout_flag_ff;
  reg        powerdown_flag_ff;
  reg [7:0]  result_ff;
  reg [7:0]  watchdog_counter_ff;
  reg [WDOG_PRESC_W-1:0] wdog_presc_ff;
  reg        exec_ff;

  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;
  wire       alu_z;

  // ==========================================================
  // Arithmetic core
  srxeu_alu u_alu (
    .op_i    (op_ff),
    .acc_i   (acc_ff),
    .file_i  (file_ff),
    .lit_i   (lit_ff),
    .carry_i (carry_ff),
    .res_o   (alu_res),
    .carry_o (alu_c),
    .dc_o    (alu_dc),
    .zero_o  (alu_z)
  );

  // ==========================================================
  // APB decode; zero-wait slave, answers in the access cycle
  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr    = psel_i & penable_i & pwrite_i & pready_o;
  wire addr_ok   = (paddr_i[1:0] == 2'b00) && (paddr_i <= `SRXEU_REG_WDOG);
  wire wr_ctrl   = apb_wr & addr_ok & (paddr_i == `SRXEU_REG_CTRL) & pstrb_i[0];
  wire wr_opnd   = apb_wr & addr_ok & (paddr_i == `SRXEU_REG_OPND);
  wire wr_acc    = apb_wr & addr_ok & (paddr_i == `SRXEU_REG_ACC) & pstrb_i[0];
  wire wr_file   = apb_wr & addr_ok & (paddr_i == `SRXEU_REG_FILE) & pstrb_i[0];
  wire go        = wr_ctrl & pwdata_i[`SRXEU_CTRL_GO] & ~osc_halt_o;
  wire wake      = wr_ctrl & pwdata_i[`SRXEU_CTRL_WAKE];

  // Read mux from registered state only
  reg [31:0] nxt_prdata;
  always @* begin
    nxt_prdata = 32'h0000_0000;
    case (paddr_i)
      `SRXEU_REG_CTRL:   nxt_prdata = {27'h0, dest_ff, op_ff};
      `SRXEU_REG_OPND:   nxt_prdata = {17'h0, faddr_ff, lit_ff};
      `SRXEU_REG_ACC:    nxt_prdata = {24'h0, acc_ff};
      `SRXEU_REG_STATUS: nxt_prdata = {26'h0, osc_halt_o, timeout_flag_ff,
                                       powerdown_flag_ff, zero_ff,
                                       digit_carry_flag_ff, carry_ff};
      `SRXEU_REG_RESULT: nxt_prdata = {24'h0, result_ff};
      `SRXEU_REG_FILE:   nxt_prdata = {24'h0, file_ff};
      `SRXEU_REG_DIR:    nxt_prdata = {8'h0, port_c_direction_o,
                                       port_b_direction_o, port_a_direction_o};
      `SRXEU_REG_WDOG:   nxt_prdata = {24'h0, watchdog_counter_ff};
      default:           nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Bus answer registers
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & ~addr_ok;
      if (apb_setup & ~pwrite_i) begin
        prdata_o <= addr_ok ? nxt_prdata : 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Command capture: any control write latches op and dest; a go write executes next unless halted
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_ff    <= `SRXEU_OP_NOP;
      dest_ff  <= 1'b0;
      lit_ff   <= `SRXEU_RST_BYTE;
      faddr_ff <= 7'h00;
      exec_ff  <= 1'b0;
    end else if (clk_en_i) begin
      exec_ff <= go;
      if (wr_ctrl) begin
        op_ff   <= pwdata_i[3:0];
        dest_ff <= pwdata_i[`SRXEU_CTRL_DEST];
      end
      if (wr_opnd & pstrb_i[0]) begin
        lit_ff <= pwdata_i[7:0];
      end
      if (wr_opnd & pstrb_i[1]) begin
        faddr_ff <= pwdata_i[14:8];
      end
    end
  end

  // ==========================================================
  // Destination routing; xor-literal and literal subtract go to acc
  wire to_file = exec_ff & dest_ff &
                 ((op_ff == `SRXEU_OP_ROT_RC) | (op_ff == `SRXEU_OP_REG_SUB) |
                  (op_ff == `SRXEU_OP_REG_SUBB) | (op_ff == `SRXEU_OP_NIB_X) |
                  (op_ff == `SRXEU_OP_XOR_REG));
  wire alu_op  = (op_ff == `SRXEU_OP_ROT_RC) | (op_ff == `SRXEU_OP_LIT_SUB) |
                 (op_ff == `SRXEU_OP_REG_SUB) | (op_ff == `SRXEU_OP_REG_SUBB) |
                 (op_ff == `SRXEU_OP_NIB_X) | (op_ff == `SRXEU_OP_XOR_LIT) |
                 (op_ff == `SRXEU_OP_XOR_REG);
  wire to_acc  = exec_ff & alu_op & ~to_file;
  wire is_sub  = (op_ff == `SRXEU_OP_LIT_SUB) | (op_ff == `SRXEU_OP_REG_SUB) |
                 (op_ff == `SRXEU_OP_REG_SUBB);
  wire is_xor  = (op_ff == `SRXEU_OP_XOR_LIT) | (op_ff == `SRXEU_OP_XOR_REG);

  // Accumulator and file byte; execution wins over a bus write
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_ff    <= `SRXEU_RST_BYTE;
      file_ff   <= `SRXEU_RST_BYTE;
      result_ff <= `SRXEU_RST_BYTE;
    end else if (clk_en_i) begin
      if (exec_ff & alu_op) begin
        result_ff <= alu_res;
      end
      if (to_acc) begin
        acc_ff <= alu_res;
      end else if (wr_acc) begin
        acc_ff <= pwdata_i[7:0];
      end
      if (to_file) begin
        file_ff <= alu_res;
      end else if (wr_file) begin
        file_ff <= pwdata_i[7:0];
      end
    end
  end

  // ==========================================================
  // Arithmetic flags; swap and direction load leave them alone
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      carry_ff            <= 1'b0;
      digit_carry_flag_ff <= 1'b0;
      zero_ff             <= 1'b0;
    end else if (clk_en_i) begin
      if (exec_ff & (is_sub | (op_ff == `SRXEU_OP_ROT_RC))) begin
        carry_ff <= alu_c;
      end
      if (exec_ff & is_sub) begin
        digit_carry_flag_ff <= alu_dc;
      end
      if (exec_ff & (is_sub | is_xor)) begin
        zero_ff <= alu_z;
      end
    end
  end

  // ==========================================================
  // Port direction registers; unknown operand loads nothing
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_a_direction_o <= `SRXEU_RST_DIR;
      port_b_direction_o <= `SRXEU_RST_DIR;
      port_c_direction_o <= `SRXEU_RST_DIR;
    end else if (clk_en_i && exec_ff && (op_ff == `SRXEU_OP_DIR_LOAD)) begin
      case (faddr_ff)
        `SRXEU_DIR_PORT_A: port_a_direction_o <= acc_ff;
        `SRXEU_DIR_PORT_B: port_b_direction_o <= acc_ff;
        `SRXEU_DIR_PORT_C: port_c_direction_o <= acc_ff;
        default: port_a_direction_o <= port_a_direction_o;
      endcase
    end
  end

  // ==========================================================
  // Watchdog, power flags and sleep; halt stays until a wake write
  wire do_sleep = exec_ff & (op_ff == `SRXEU_OP_SLEEP);
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_counter_ff <= `SRXEU_WDOG_CLEAR;
      wdog_presc_ff       <= {WDOG_PRESC_W{1'b0}};
      timeout_flag_ff     <= 1'b1;
      powerdown_flag_ff   <= 1'b1;
      osc_halt_o          <= 1'b0;
      busy_o              <= 1'b0;
    end else if (clk_en_i) begin
      busy_o <= go;
      if (do_sleep) begin
        watchdog_counter_ff <= `SRXEU_WDOG_CLEAR;
        wdog_presc_ff       <= {WDOG_PRESC_W{1'b0}};
        timeout_flag_ff     <= 1'b1;
        powerdown_flag_ff   <= 1'b0;
        osc_halt_o          <= 1'b1;
      end else if (wake) begin
        osc_halt_o <= 1'b0;
      end else if (~osc_halt_o) begin
        // Free-running watchdog while awake; prescaler wrap ticks it
        wdog_presc_ff <= wdog_presc_ff + {{(WDOG_PRESC_W-1){1'b0}}, 1'b1};
        if (&wdog_presc_ff) begin
          watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
        end
      end
    end
  end
endmodule // srxeu_top
`default_nettype wire

// ### dv/srxeu_chk.sv
// Port-level assertions for the subtract / rotate / xor execution unit.
// Assumes binding onto srxeu_top; one clock domain, reset high.
`timescale 1ns/1ps
`default_nettype none
`include "srxeu_defines.vh"
module srxeu_chk (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        clk_en_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  port_a_direction_o,
  input wire logic [7:0]  port_b_direction_o,
  input wire logic [7:0]  port_c_direction_o,
  input wire logic        osc_halt_o,
  input wire logic        busy_o
);
  // ==========================================================
  // Accepted go write; wake in the same word is left out as unclear
  wire       go_w = psel_i & penable_i & pready_o & pwrite_i & clk_en_i & pwdata_i[`SRXEU_CTRL_GO] &
                    ~pwdata_i[`SRXEU_CTRL_WAKE] & (paddr_i == `SRXEU_REG_CTRL);
  wire [3:0] op_w = pwdata_i[3:0];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Bus answer timing
  a_pready_after_setup: assert property (psel_i & ~penable_i & clk_en_i |=> pready_o)
    else $error("pready missing after setup");
  a_pready_one_cycle: assert property (pready_o & clk_en_i |=> !pready_o)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_bad_addr_err: assert property (psel_i & ~penable_i & clk_en_i & ~pwrite_i &
    ((paddr_i > 12'h01c) | (paddr_i[1:0] != 2'h0)) |=> pslverr_o && prdata_o == 32'h0)
    else $error("bad address not refused");
  // ==========================================================
  // Execution and sleep
  a_go_gives_busy: assert property (go_w & ~osc_halt_o |=> busy_o)
    else $error("go write did not execute");
  a_busy_one_pulse: assert property (busy_o & clk_en_i |=> !busy_o)
    else $error("busy longer than one cycle");
  a_sleep_halts_osc: assert property (go_w & ~osc_halt_o & (op_w == `SRXEU_OP_SLEEP) ##1 clk_en_i |=> osc_halt_o)
    else $error("sleep did not halt");
  a_halt_blocks_go: assert property (go_w & osc_halt_o |=> !busy_o)
    else $error("go executed while halted");
  a_halt_from_exec: assert property ($rose(osc_halt_o) |-> $past(busy_o))
    else $error("halt rose without execution");
  a_dir_from_exec: assert property ($changed({port_a_direction_o, port_b_direction_o, port_c_direction_o}) |->
    $past(busy_o)) else $error("direction changed without execution");
endmodule // srxeu_chk
bind srxeu_top srxeu_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .port_a_direction_o(port_a_direction_o),
  .port_b_direction_o(port_b_direction_o), .port_c_direction_o(port_c_direction_o), .osc_halt_o(osc_halt_o),
  .busy_o(busy_o));
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench: APB master, reference model, random and corner ops.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "srxeu_defines.vh"
module tb;
  logic        mclk_i = 0, sys_rst_i = 1, clk_en_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd_v;
  logic [7:0]  dir_a, dir_b, dir_c, m_acc, m_file, m_lit, m_res;
  logic [6:0]  m_fa;
  logic [23:0] m_dir;
  logic        pready_o, pslverr_o, osc_halt_o, busy_o, last_err, m_c, m_dc, m_z, m_pwrdn, m_to, m_halt;
  int          n_errors = 0, n_checks = 0;
  srxeu_top #(.WDOG_PRESC_W(2)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port_a_direction_o(dir_a), .port_b_direction_o(dir_b), .port_c_direction_o(dir_c),
    .osc_halt_o(osc_halt_o), .busy_o(busy_o));
  // ==========================================================
  // Clock and watchdog; the limit is well past the expected run
  initial forever #25 mclk_i = ~mclk_i;
  initial begin
    #(40000 * 50);
    n_errors++;
    report_and_stop();
  end
  // ==========================================================
  // Comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // No own limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd_v = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // ==========================================================
  // Reference model; carry set means no borrow
  // Returns {carry, digit carry, difference}
  function automatic logic [9:0] sub_f(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, ~b} + {8'h0, ci};
    return {s[8], (({1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci}) > 5'h0f), s[7:0]};
  endfunction
  task automatic run(input logic [3:0] op, input logic d);
    if (m_halt) return;
    case (op)
      `SRXEU_OP_ROT_RC: begin
        m_res = {m_c, m_file[7:1]};
        m_c = m_file[0];
      end
      `SRXEU_OP_LIT_SUB: {m_c, m_dc, m_res} = sub_f(m_lit, m_acc, 1'b1);
      `SRXEU_OP_REG_SUB: {m_c, m_dc, m_res} = sub_f(m_file, m_acc, 1'b1);
      `SRXEU_OP_REG_SUBB: {m_c, m_dc, m_res} = sub_f(m_file, m_acc, m_c);
      `SRXEU_OP_NIB_X: m_res = {m_file[3:0], m_file[7:4]};
      `SRXEU_OP_XOR_LIT: m_res = m_acc ^ m_lit;
      `SRXEU_OP_XOR_REG: m_res = m_acc ^ m_file;
      `SRXEU_OP_SLEEP: {m_halt, m_pwrdn, m_to} = 3'b101;
      `SRXEU_OP_DIR_LOAD: if (m_fa >= 7'h05 && m_fa <= 7'h07) m_dir[(m_fa - 7'h05) * 8 +: 8] = m_acc;
      default: ;
    endcase
    if (op inside {4'h2, 4'h3, 4'h4, 4'h8, 4'h9}) m_z = (m_res == 8'h00);
    if (op inside {4'h2, 4'h8} || (op inside {4'h1, 4'h3, 4'h4, 4'h6, 4'h9} && !d)) m_acc = m_res;
    else if (op inside {4'h1, 4'h3, 4'h4, 4'h6, 4'h9}) m_file = m_res;
  endtask
  // Read back acc, file, status and direction state and compare with the model
  task automatic chk_all();
    apb(1'b0, `SRXEU_REG_ACC, 32'h0);
    chk("acc", rd_v, {24'h0, m_acc});
    apb(1'b0, `SRXEU_REG_FILE, 32'h0);
    chk("file", rd_v, {24'h0, m_file});
    apb(1'b0, `SRXEU_REG_STATUS, 32'h0);
    chk("status", rd_v, {26'h0, m_halt, m_to, m_pwrdn, m_z, m_dc, m_c});
    apb(1'b0, `SRXEU_REG_DIR, 32'h0);
    chk("dir", rd_v, {8'h0, m_dir});
    chk("dir_pins", {8'h0, dir_c, dir_b, dir_a}, {8'h0, m_dir});
  endtask
  task automatic do_op(input logic [3:0] op, input logic d);
    apb(1'b1, `SRXEU_REG_ACC, {24'h0, m_acc});
    apb(1'b1, `SRXEU_REG_FILE, {24'h0, m_file});
    apb(1'b1, `SRXEU_REG_OPND, {17'h0, m_fa, m_lit});
    apb(1'b1, `SRXEU_REG_CTRL, {26'h0, d, 1'b1, op});
    run(op, d);
    chk_all();
  endtask
  // ==========================================================
  // Main sequence: reset, refusals, corners, random, sleep and wake
  initial begin
    logic [27:0] cv [6];
    logic [3:0]  op;
    cv = '{28'h2100010, 28'h2110010, 28'h3011000, 28'h4000000, 28'h3010000, 28'h4000000};
    void'($urandom(32'ha8a7));
    {m_acc, m_file, m_lit, m_fa, m_dir} = {31'h0, 24'hffffff};
    {m_c, m_dc, m_z, m_pwrdn, m_to, m_halt} = 6'b000110;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk_all();
    apb(1'b0, 12'h020, 32'h0);
    chk("bad_err", {31'h0, last_err}, 32'h1);
    chk("bad_data", rd_v, 32'h0);
    apb(1'b1, 12'h009, 32'hff);
    chk("odd_err", {31'h0, last_err}, 32'h1);
    chk_all();
    // Equal operands, borrow out and borrow in before random traffic
    foreach (cv[i]) begin
      {m_acc, m_file, m_lit} = cv[i][23:0];
      do_op(cv[i][27:24], 1'b0);
    end
    // Enable held low over the execute edge must stall a direction load
    m_acc = 8'h5a;
    m_fa = 7'h05;
    apb(1'b1, `SRXEU_REG_ACC, {24'h0, m_acc});
    apb(1'b1, `SRXEU_REG_OPND, {17'h0, m_fa, m_lit});
    apb(1'b1, `SRXEU_REG_CTRL, {28'h001, `SRXEU_OP_DIR_LOAD});
    clk_en_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk("dir_frozen", {24'h0, dir_a}, {24'h0, m_dir[7:0]});
    clk_en_i <= 1'b1;
    run(`SRXEU_OP_DIR_LOAD, 1'b0);
    chk_all();
    repeat (250) begin
      m_acc = 8'($urandom);
      m_file = 8'($urandom);
      m_lit = 8'($urandom);
      m_fa = 7'($urandom_range(8, 4));
      op = 4'($urandom_range(9, 1));
      if (op == `SRXEU_OP_SLEEP) op = `SRXEU_OP_DIR_LOAD;
      do_op(op, 1'($urandom));
    end
    do_op(`SRXEU_OP_SLEEP, 1'b0);
    apb(1'b0, `SRXEU_REG_WDOG, 32'h0);
    chk("wdog", rd_v, 32'h0);
    chk("halt", {31'h0, osc_halt_o}, 32'h1);
    do_op(`SRXEU_OP_XOR_LIT, 1'b0);
    apb(1'b1, `SRXEU_REG_CTRL, 32'h40);
    m_halt = 1'b0;
    do_op(`SRXEU_OP_XOR_REG, 1'b1);
    // Mid-run reset must bring back directions and status defaults
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    {m_acc, m_file, m_lit, m_fa, m_dir} = {31'h0, 24'hffffff};
    {m_c, m_dc, m_z, m_pwrdn, m_to, m_halt} = 6'b000110;
    chk_all();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
